// ===== sws_pkg.sv
// Purpose: Shared constants and types for the supply supervisor watchdog
// Assumes: 40 MHz mclk, synchronous active-high reset
// Notes: All timed intervals are counted in 1 ms ticks of the time base
package sws_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 25;

  // Time base: one tick per millisecond
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 16;

  // Reset pulse, nominal and least extension
  localparam int RESET_PULSE_MS = 200;
  localparam int RESET_EXTEND_MIN_MS = 140;
  localparam int RST_W = 8;
  localparam logic [RST_W-1:0] RESET_TICKS = RST_W'(RESET_PULSE_MS);
  localparam logic [RST_W-1:0] RESET_TIMER_INIT = RESET_TICKS;

  // Watchdog timeout
  localparam real WD_TIMEOUT_S = 1.6;
  localparam int WD_W = 11;
  localparam logic [WD_W-1:0] WD_TICKS = WD_W'(int'(WD_TIMEOUT_S * 1000.0));
  localparam logic [WD_W-1:0] WD_COUNT_INIT = 11'h000;

  // Least kick pulse, rounded up to whole cycles
  localparam int KICK_MIN_NS = 50;
  localparam int KICK_MIN_CYC =
    (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Values of the input synchroniser during reset
  localparam int SYNC_W = 5;

  typedef struct packed {
    logic supply_ok;
    logic pf_above_ref;
    logic manual_reset_n;
    logic kick;
    logic kick_driven;
  } sws_in_t;

  localparam sws_in_t SYNC_RESET_VAL = '{
    supply_ok: 1'b0,
    pf_above_ref: 1'b1,
    manual_reset_n: 1'b1,
    kick: 1'b0,
    kick_driven: 1'b0
  };

endpackage : sws_pkg

// ===== sws_sync.sv
// Purpose: Two-flop synchroniser for the supervisor's pin inputs
// Assumes: Inputs are asynchronous levels
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module sws_sync
  import sws_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire sws_in_t async_in,
  output sws_in_t sync_out
);

  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] stable_reg;
  logic [SYNC_W-1:0] rst_val;

  assign rst_val = SYNC_RESET_VAL;

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (reset) begin
          meta_reg[gi] <= rst_val[gi];
          stable_reg[gi] <= rst_val[gi];
        end else begin
          meta_reg[gi] <= async_in[gi];
          stable_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign sync_out = stable_reg;

endmodule : sws_sync

// ===== sws_supervisor.sv
// Purpose: Supply supervisor with reset stretcher, manual reset and watchdog
// Assumes: Analog comparisons arrive as digital levels on pins
// Notes: All intervals come from a free-running 1 ms tick
//
// How it works
// R1: Reset released 200 ms after supply ok
// R2: Supply low asserts reset while it lasts
// R3: Brownout mid-pulse extends reset at least 140 ms
// R4: Active-high reset is exact complement
// R5: No kick for 1.6 s drives expired low
// R6: Watchdog cleared while reset or kick tri-stated
// R7: Watchdog counts once reset released and driven
// R8: Kick pulses of 50 ns are detected
// R9: Supply low forces expired output low
// R10: Floating kick makes expired a low-line flag
// R11: Power-fail warn follows sense, independent of reset
// R12: Manual reset starts at least 140 ms pulse
// R13: System routes expired output to manual reset
// R14: Expiry alone never asserts reset
// R15: Expired sticky until cleared, rises on recovery
// R16: Reset held 200 ms after manual reset release
// R17: Any kick edge restarts the watchdog
// R18: Synchronised comparator inputs, free-running time base
`timescale 1ns/10ps
module sws_supervisor
  import sws_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic supply_ok_in,
  input wire logic power_fail_sense_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_driven_in,
  output logic reset_n_out,
  output logic reset_out,
  output logic watchdog_expired_n_out,
  output logic power_fail_warn_n_out
);

  sws_in_t pins_async;
  sws_in_t pins_s;

  logic [DIV_W-1:0] div_reg;
  logic tick_reg;
  logic [RST_W-1:0] rst_timer_reg;
  logic [WD_W-1:0] wd_count_reg;
  logic wd_expired_reg;
  logic kick_prev_reg;
  logic reset_n_reg;
  logic reset_reg;
  logic wdo_n_reg;
  logic pfo_n_reg;

  logic hold;
  logic rst_active;
  logic kick_edge;
  logic wd_clear;
  logic wd_expired_next;

  assign pins_async = '{
    supply_ok: supply_ok_in,
    pf_above_ref: power_fail_sense_in,
    manual_reset_n: manual_reset_n_in,
    kick: watchdog_kick_in,
    kick_driven: watchdog_kick_driven_in
  };

  // Every pin level crosses two flops before use
  sws_sync u_sync ( // [R18]
    .mclk(mclk),
    .reset(reset),
    .async_in(pins_async),
    .sync_out(pins_s)
  );

  // Free-running millisecond time base
  always_ff @(posedge mclk) begin // [R18]
    if (reset) begin
      div_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_W'(TICK_CYCLES - 1)) begin
      div_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // Reset is held by a low supply or a pressed manual reset only
  assign hold = !pins_s.supply_ok || !pins_s.manual_reset_n; // [R2] [R14]
  assign rst_active = hold || (rst_timer_reg != 8'h00);

  // Reloading on every held cycle gives the full interval after release,
  // which also covers any brownout or bounce inside a running pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      rst_timer_reg <= RESET_TIMER_INIT;
    end else if (hold) begin
      rst_timer_reg <= RESET_TICKS; // [R3] [R12] [R16]
    end else if (tick_reg && rst_timer_reg != 8'h00) begin
      rst_timer_reg <= rst_timer_reg - 8'h01; // [R1]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reset_n_reg <= 1'b0;
      reset_reg <= 1'b1;
    end else begin
      reset_n_reg <= !rst_active; // [R1] [R2]
      reset_reg <= rst_active; // [R4]
    end
  end

  // Kick edges; two synchronised samples of a 50 ns pulse at 25 ns
  always_ff @(posedge mclk) begin
    if (reset) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= pins_s.kick;
    end
  end

  assign kick_edge = pins_s.kick ^ kick_prev_reg; // [R8] [R17]
  assign wd_clear = rst_active || !pins_s.kick_driven || kick_edge; // [R6]

  always_ff @(posedge mclk) begin
    if (reset) begin
      wd_count_reg <= WD_COUNT_INIT;
    end else if (wd_clear) begin
      wd_count_reg <= WD_COUNT_INIT; // [R6] [R10] [R17]
    end else if (tick_reg && wd_count_reg != WD_TICKS) begin
      wd_count_reg <= wd_count_reg + 11'h001; // [R7]
    end
  end

  // Sticky until the timer is cleared
  always_comb begin
    if (wd_clear) begin
      wd_expired_next = 1'b0;
    end else if (wd_count_reg == WD_TICKS) begin
      wd_expired_next = 1'b1; // [R5]
    end else begin
      wd_expired_next = wd_expired_reg; // [R15]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wd_expired_reg <= 1'b0;
    end else begin
      wd_expired_reg <= wd_expired_next;
    end
  end

  // Low line overrides; recovery releases with no minimum width
  always_ff @(posedge mclk) begin
    if (reset) begin
      wdo_n_reg <= 1'b0;
    end else begin
      wdo_n_reg <= pins_s.supply_ok && !wd_expired_next; // [R9] [R15]
    end
  end

  // Comparator path has no link to the reset logic
  always_ff @(posedge mclk) begin
    if (reset) begin
      pfo_n_reg <= 1'b1;
    end else begin
      pfo_n_reg <= pins_s.pf_above_ref; // [R11]
    end
  end

  assign reset_n_out = reset_n_reg;
  assign reset_out = reset_reg;
  assign watchdog_expired_n_out = wdo_n_reg;
  assign power_fail_warn_n_out = pfo_n_reg;

  property p_complement;
    @(posedge mclk) disable iff (reset)
    reset_out == !reset_n_out;
  endproperty
  a_complement: assert property (p_complement) // [R4]
    else $error("reset outputs not complementary");

  property p_brownout;
    @(posedge mclk) disable iff (reset)
    !pins_s.supply_ok |=> !reset_n_out && !watchdog_expired_n_out;
  endproperty
  a_brownout: assert property (p_brownout) // [R2]
    else $error("low supply did not assert reset and expired");

  property p_lowline;
    @(posedge mclk) disable iff (reset)
    (!pins_s.supply_ok && reset_n_out) |=>
      $fell(reset_n_out) && !watchdog_expired_n_out;
  endproperty
  a_lowline: assert property (p_lowline) // [R9]
    else $error("expired did not fall together with reset");

  property p_reload;
    @(posedge mclk) disable iff (reset)
    hold |=> rst_timer_reg == RESET_TICKS;
  endproperty
  a_reload: assert property (p_reload) // [R3]
    else $error("reset timer not reloaded while held");

  property p_release;
    @(posedge mclk) disable iff (reset)
    $rose(reset_n_out) |-> $past(rst_timer_reg) == 8'h00 &&
      $past(pins_s.supply_ok) && $past(pins_s.manual_reset_n);
  endproperty
  a_release: assert property (p_release) // [R1]
    else $error("reset released before interval ended");

  property p_no_wd_reset;
    @(posedge mclk) disable iff (reset)
    (!hold && rst_timer_reg == 8'h00) |=> reset_n_out;
  endproperty
  a_no_wd_reset: assert property (p_no_wd_reset) // [R14]
    else $error("reset asserted without supply or manual cause");

  property p_wd_cleared;
    @(posedge mclk) disable iff (reset)
    (rst_active || !pins_s.kick_driven || kick_edge) |=>
      wd_count_reg == 11'h000 && !wd_expired_reg;
  endproperty
  a_wd_cleared: assert property (p_wd_cleared) // [R6]
    else $error("watchdog not cleared");

  property p_expire;
    @(posedge mclk) disable iff (reset)
    (wd_count_reg == WD_TICKS && !wd_clear && pins_s.supply_ok) |=>
      !watchdog_expired_n_out;
  endproperty
  a_expire: assert property (p_expire) // [R5]
    else $error("timeout did not drive expired low");

  property p_recover;
    @(posedge mclk) disable iff (reset)
    $rose(pins_s.supply_ok) |=> watchdog_expired_n_out;
  endproperty
  a_recover: assert property (p_recover) // [R15]
    else $error("expired did not rise on supply recovery");

  property p_pfo;
    @(posedge mclk) disable iff (reset)
    !$past(reset) |-> power_fail_warn_n_out == $past(pins_s.pf_above_ref);
  endproperty
  a_pfo: assert property (p_pfo) // [R11]
    else $error("power fail warn does not follow sense");

  property p_count;
    @(posedge mclk) disable iff (reset)
    (!wd_clear && tick_reg && wd_count_reg != WD_TICKS) |=>
      wd_count_reg == $past(wd_count_reg) + 11'h001;
  endproperty
  a_count: assert property (p_count) // [R7]
    else $error("watchdog did not count");

endmodule : sws_supervisor

// ===== sws_cpu_model.sv
// Purpose: Processor side of the supervisor, kicking the watchdog pin
// Assumes: Pin level changes just after a rising edge of mclk
// Notes: Kick gap must stay well under the watchdog timeout
`timescale 1ns/10ps
module sws_cpu_model #(
  parameter int KICK_GAP = 500
) (
  input wire logic mclk,
  input wire logic run,
  input wire logic drive,
  output logic watchdog_kick_in,
  output logic watchdog_kick_driven_in
);
  int cnt_reg = 0;
  logic lvl_reg = 1'h0;
  logic pin_reg = 1'h0;
  // Each level held KICK_GAP cycles, far above the shortest kick
  always @(posedge mclk) begin
    cnt_reg <= (run && cnt_reg >= KICK_GAP - 1) ? 0 : cnt_reg + 1;
    if (run && cnt_reg >= KICK_GAP - 1) lvl_reg <= ~lvl_reg;
  end
  // A floating pin shows a changing pattern, never a frozen level
  always @(posedge mclk) begin
    pin_reg <= drive ? lvl_reg : ~pin_reg;
  end
  assign watchdog_kick_in = pin_reg;
  assign watchdog_kick_driven_in = drive;
endmodule : sws_cpu_model

// ===== test_supply_supervisor_watchdog.sv
// Purpose: Self-checking bench for the supply supervisor watchdog
// Assumes: TICK_CYCLES of 10, so 1 ms is 10 mclk cycles
// Notes: Windows allow for tick phase and the input synchroniser
`timescale 1ns/10ps
module test_supply_supervisor_watchdog;
  import sws_pkg::*;
  localparam int TC = 10;
  localparam int RST_CYC = RESET_PULSE_MS * TC;
  localparam int WD_CYC = int'(WD_TICKS) * TC;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic supply_ok_in = 1'h1;
  logic power_fail_sense_in = 1'h1;
  logic manual_reset_n_in = 1'h1;
  logic run = 1'h1;
  logic drive = 1'h1;
  logic route = 1'h0;
  logic watchdog_kick_in, watchdog_kick_driven_in;
  logic reset_n_out, reset_out, watchdog_expired_n_out;
  logic power_fail_warn_n_out;
  int failures = 0;
  int n_tests = 0;
  int n;
  always #12.5 mclk = ~mclk;
  sws_supervisor #(.TICK_CYCLES(TC)) sws_supervisor_i (
    .mclk(mclk), .reset(reset), .supply_ok_in(supply_ok_in),
    .power_fail_sense_in(power_fail_sense_in),
    .manual_reset_n_in(manual_reset_n_in &&
      (watchdog_expired_n_out || !route)),
    .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_driven_in(watchdog_kick_driven_in),
    .reset_n_out(reset_n_out), .reset_out(reset_out),
    .watchdog_expired_n_out(watchdog_expired_n_out),
    .power_fail_warn_n_out(power_fail_warn_n_out));
  sws_cpu_model sws_cpu_model_i (
    .mclk(mclk), .run(run), .drive(drive),
    .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_driven_in(watchdog_kick_driven_in));
  task automatic check(logic seen, logic exp, string msg);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : check
  // Sampling on the falling edge keeps clear of the input updates
  task automatic cyc(int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  task automatic rst_is(logic e);
    check(reset_n_out, e, "reset_n_out");
    check(reset_out, ~e, "reset_out not complement");
  endtask : rst_is
  task automatic t_power_up;
    cyc(RST_CYC - 15);
    rst_is(1'h0);
    cyc(25);
    rst_is(1'h1);
    $display("test power_up done");
  endtask : t_power_up
  task automatic t_brownout;
    @(posedge mclk) supply_ok_in <= 1'h0;
    cyc(4);
    rst_is(1'h0);
    check(watchdog_expired_n_out, 1'h0, "expired not low");
    cyc(20);
    rst_is(1'h0);
    @(posedge mclk) supply_ok_in <= 1'h1;
    cyc(4);
    check(watchdog_expired_n_out, 1'h1, "expired not back");
    cyc(1000);
    // Second dip lands in the middle of the running pulse
    @(posedge mclk) supply_ok_in <= 1'h0;
    repeat (2) @(posedge mclk);
    supply_ok_in <= 1'h1;
    cyc(140 * TC - 5);
    rst_is(1'h0);
    cyc(RST_CYC - 140 * TC + 20);
    rst_is(1'h1);
    $display("test brownout done");
  endtask : t_brownout
  task automatic t_manual;
    @(posedge mclk) manual_reset_n_in <= 1'h0;
    cyc(4);
    rst_is(1'h0);
    // Contact bounce: extra presses must not add pulses
    for (int i = 0; i < 3; i++) begin
      repeat (3) @(posedge mclk);
      manual_reset_n_in <= !i[0];
    end
    cyc(RST_CYC - 15);
    rst_is(1'h0);
    cyc(25);
    rst_is(1'h1);
    $display("test manual done");
  endtask : t_manual
  task automatic t_watchdog;
    cyc(WD_CYC + 500);
    check(watchdog_expired_n_out, 1'h1, "expired while kicked");
    @(posedge mclk) run <= 1'h0;
    drive <= 1'h0;
    cyc(10);
    check(watchdog_expired_n_out, 1'h1, "expired while floating");
    @(posedge mclk) drive <= 1'h1;
    n = 0;
    while (watchdog_expired_n_out === 1'h1 && n < WD_CYC + 100) begin
      cyc(1);
      n++;
    end
    check(n >= WD_CYC - 15 && n <= WD_CYC + 10, 1'h1, "timeout");
    cyc(100);
    check(watchdog_expired_n_out, 1'h0, "expired not held");
    rst_is(1'h1);
    @(posedge mclk) run <= 1'h1;
    cyc(505);
    check(watchdog_expired_n_out, 1'h1, "kick did not clear");
    $display("test watchdog done");
  endtask : t_watchdog
  // Expiry wired back to manual reset must give a full reset pulse
  task automatic t_route;
    @(posedge mclk) run <= 1'h0;
    route <= 1'h1;
    cyc(WD_CYC + 100);
    rst_is(1'h0);
    check(watchdog_expired_n_out, 1'h1, "reset did not clear");
    @(posedge mclk) route <= 1'h0;
    cyc(RST_CYC + 200);
    rst_is(1'h1);
    @(posedge mclk) run <= 1'h1;
    $display("test route done");
  endtask : t_route
  task automatic t_float;
    @(posedge mclk) drive <= 1'h0;
    cyc(WD_CYC + 1000);
    check(watchdog_expired_n_out, 1'h1, "floating timer ran");
    @(posedge mclk) supply_ok_in <= 1'h0;
    cyc(4);
    check(watchdog_expired_n_out, 1'h0, "no low-line flag");
    @(posedge mclk) supply_ok_in <= 1'h1;
    cyc(RST_CYC + 10);
    @(posedge mclk) drive <= 1'h1;
    $display("test float done");
  endtask : t_float
  task automatic t_power_fail;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk) power_fail_sense_in <= i[0];
      cyc(4);
      check(power_fail_warn_n_out, i[0], "warn level");
      rst_is(1'h1);
    end
    $display("test power_fail done");
  endtask : t_power_fail
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'h0;
    t_power_up();
    t_brownout();
    t_manual();
    t_watchdog();
    t_route();
    t_float();
    t_power_fail();
    test_done();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    test_done();
  end
endmodule : test_supply_supervisor_watchdog
